// *** hdl/bertei_pkg.sv ***
// Purpose: shared constants of the error insertion and bit count block
// Assumes: APB byte address = 4 x register index, data in the low byte
// Notes:   register indices, field positions and reset values live here
package bertei_pkg;

    localparam int unsigned ST_W = 3;

    // register indices
    localparam logic [5:0] IDX_SEED3    = 6'h00;
    localparam logic [5:0] IDX_SEED2    = 6'h01;
    localparam logic [5:0] IDX_SEED1    = 6'h02;
    localparam logic [5:0] IDX_SEED0    = 6'h03;
    localparam logic [5:0] IDX_LENGTH   = 6'h04;
    localparam logic [5:0] IDX_TAPS     = 6'h05;
    localparam logic [5:0] IDX_PCTRL    = 6'h06;
    localparam logic [5:0] IDX_EINJ     = 6'h07;
    localparam logic [5:0] IDX_BITS3    = 6'h08;
    localparam logic [5:0] IDX_BITS2    = 6'h09;
    localparam logic [5:0] IDX_BITS1    = 6'h0a;
    localparam logic [5:0] IDX_BITS0    = 6'h0b;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h18;
    localparam logic [5:0] IDX_IRQ_CLR  = 6'h19;
    localparam logic [5:0] IDX_IRQ_EN   = 6'h1a;

    // error_inject_control fields
    localparam int unsigned EINJ_RATE_LO = 0;
    localparam int unsigned EINJ_SINGLE  = 3;
    localparam int unsigned EINJ_RX_INV  = 4;
    localparam int unsigned EINJ_TX_INV  = 5;
    localparam logic [7:0]  EINJ_MASK    = 8'h3f;

    // pattern_control fields
    localparam int unsigned PC_LATCH = 4;
    localparam int unsigned PC_TYPE  = 5;
    localparam int unsigned PC_ZSUP  = 6;
    localparam int unsigned PC_LOAD  = 7;

    // interrupt status bits
    localparam int unsigned ST_OVF     = 0;
    localparam int unsigned ST_LATCHED = 1;
    localparam int unsigned ST_ERR_INS = 2;

    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [31:0] RST_SEED     = 32'hffffffff;
    localparam logic [4:0]  ZSUP_RUN     = 5'h0e;

    // bits between automatic errors per rate code
    localparam logic [23:0] DEC_1 = 24'h00000a;
    localparam logic [23:0] DEC_2 = 24'h000064;
    localparam logic [23:0] DEC_3 = 24'h0003e8;
    localparam logic [23:0] DEC_4 = 24'h002710;
    localparam logic [23:0] DEC_5 = 24'h0186a0;
    localparam logic [23:0] DEC_6 = 24'h0f4240;
    localparam logic [23:0] DEC_7 = 24'h989680;

endpackage : bertei_pkg

// *** hdl/bertei_sync.sv ***
// Purpose: two-stage synchroniser for a group of asynchronous levels
// Assumes: each bit is an independent level; no bus coherence implied
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ns
module bertei_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,   // sampling clock
    input  wire logic         reset, // async reset, active high
    input  wire logic [W-1:0] d,     // asynchronous levels
    output logic      [W-1:0] q      // synchronised levels
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // bertei_sync

// *** hdl/bertei_top.sv ***
// Purpose: error insertion on the transmit stream and received-bit counting
// Assumes: tx_clk/rx_clk are slow pins sampled by core_clk (>= 4 cycles per half period)
// Notes:   APB slave, no wait state on any access; registers at 4 x index
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
module bertei_top (
    input  wire logic        core_clk,         // 100 MHz block clock
    input  wire logic        reset,            // async reset, active high
    input  wire logic        psel,             // apb select
    input  wire logic        penable,          // apb access phase
    input  wire logic        pwrite,           // apb write
    input  wire logic [7:0]  paddr,            // apb byte address
    input  wire logic [31:0] pwdata,           // apb write data
    output logic      [31:0] prdata,           // apb read data
    output logic             pready,           // apb ready
    output logic             pslverr,          // apb error, unmapped index
    input  wire logic        tx_clk,           // transmit link clock pin
    input  wire logic        rx_clk,           // receive link clock pin
    input  wire logic        rx_data,          // serial receive pin
    input  wire logic        rx_count_inhibit, // pin, high stops bit counting
    input  wire logic        count_latch_pin,  // pin, ored with latch bit
    input  wire logic        tx_load_pin,      // pin, ored with load bit
    input  wire logic        pattern_in_sync,  // synchroniser status, core_clk
    output logic             tx_data,          // serial transmit data
    output logic             rx_bit,           // received bit after inversion
    output logic             rx_bit_valid,     // one-cycle strobe for rx_bit
    output logic             irq               // level interrupt, active high
);
    localparam int unsigned NPIN   = 6;
    localparam int unsigned ST_W_L = bertei_pkg::ST_W;

    logic [NPIN-1:0] pin_s;
    logic            tx_clk_s;
    logic            rx_clk_s;
    logic            rx_data_s;
    logic            inhibit_s;
    logic            latch_pin_s;
    logic            load_pin_s;
    logic            tx_clk_d;
    logic            rx_clk_d;
    logic            tx_bit_en;
    logic            rx_bit_en;

    logic [7:0]      seed [4];
    logic [7:0]      plength;
    logic [7:0]      ptaps;
    logic [7:0]      pctrl;
    logic [7:0]      einj;
    logic [31:0]     bits_latched;
    logic [31:0]     bit_cnt;
    logic [ST_W_L-1:0] st_flags;
    logic [ST_W_L-1:0] st_enable;

    logic            wr_take;
    logic            setup;
    logic [5:0]      idx;
    logic [7:0]      wbyte;

    logic            latch_req;
    logic            latch_req_d;
    logic            latch_edge;
    logic            load_req;
    logic            load_req_d;
    logic            load_edge;
    logic            single_d;
    logic            single_pend;

    logic [31:0]     gen_sr;
    logic [4:0]      zrun;
    logic [23:0]     err_cnt;
    logic            gen_bit;
    logic            auto_hit;
    logic            err_now;
    logic            cnt_step;
    logic            cnt_wrap;
    logic [ST_W_L-1:0] st_set;

    bertei_sync #(
        .W (NPIN)
    ) u_pin_sync (
        .clk   (core_clk),
        .reset (reset),
        .d     ({tx_clk, rx_clk, rx_data, rx_count_inhibit, count_latch_pin, tx_load_pin}),
        .q     (pin_s)
    );

    assign {tx_clk_s, rx_clk_s, rx_data_s, inhibit_s, latch_pin_s, load_pin_s} = pin_s;

    // rate code to bits between errors
    function automatic logic [23:0] rate_run(input logic [2:0] code);
        logic [23:0] r;
        r = 24'h000000;
        unique case (code)
            3'h1: r = bertei_pkg::DEC_1;
            3'h2: r = bertei_pkg::DEC_2;
            3'h3: r = bertei_pkg::DEC_3;
            3'h4: r = bertei_pkg::DEC_4;
            3'h5: r = bertei_pkg::DEC_5;
            3'h6: r = bertei_pkg::DEC_6;
            3'h7: r = bertei_pkg::DEC_7;
            3'h0: r = 24'h000000;
        endcase
        return r;
    endfunction

    function automatic logic idx_mapped(input logic [5:0] i);
        return i <= bertei_pkg::IDX_BITS0
               || i == bertei_pkg::IDX_IRQ_STAT || i == bertei_pkg::IDX_IRQ_CLR
               || i == bertei_pkg::IDX_IRQ_EN;
    endfunction

    // link clock edges, found on the synchronised pin level
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tx_clk_d <= 1'b0;
            rx_clk_d <= 1'b0;
        end else begin
            tx_clk_d <= tx_clk_s;
            rx_clk_d <= rx_clk_s;
        end
    end

    assign tx_bit_en = tx_clk_s & ~tx_clk_d;
    assign rx_bit_en = rx_clk_s & ~rx_clk_d;

    // apb: setup cycle prepares the answer, access cycle completes it
    assign idx     = paddr[7:2];
    assign setup   = psel & ~penable;
    assign wr_take = psel & penable & pready & pwrite & ~pslverr;
    assign wbyte   = pwdata[7:0];

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~idx_mapped(idx);
            if (setup && !pwrite) begin
                unique case (idx)
                    bertei_pkg::IDX_SEED3:    prdata <= {24'h000000, seed[3]};
                    bertei_pkg::IDX_SEED2:    prdata <= {24'h000000, seed[2]};
                    bertei_pkg::IDX_SEED1:    prdata <= {24'h000000, seed[1]};
                    bertei_pkg::IDX_SEED0:    prdata <= {24'h000000, seed[0]};
                    bertei_pkg::IDX_LENGTH:   prdata <= {24'h000000, plength};
                    bertei_pkg::IDX_TAPS:     prdata <= {24'h000000, ptaps};
                    bertei_pkg::IDX_PCTRL:    prdata <= {24'h000000, pctrl};
                    bertei_pkg::IDX_EINJ:     prdata <= {24'h000000, einj};
                    bertei_pkg::IDX_BITS3:    prdata <= {24'h000000, bits_latched[31:24]};
                    bertei_pkg::IDX_BITS2:    prdata <= {24'h000000, bits_latched[23:16]};
                    bertei_pkg::IDX_BITS1:    prdata <= {24'h000000, bits_latched[15:8]};
                    bertei_pkg::IDX_BITS0:    prdata <= {24'h000000, bits_latched[7:0]};
                    bertei_pkg::IDX_IRQ_STAT: prdata <= {29'h00000000, st_flags};
                    bertei_pkg::IDX_IRQ_EN:   prdata <= {29'h00000000, st_enable};
                    default:                  prdata <= 32'h00000000;
                endcase
            end else if (setup) begin
                prdata <= 32'h00000000;
            end
        end
    end

    // software-written configuration
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 4; i++) begin
                seed[i] <= bertei_pkg::RST_BYTE;
            end
            plength   <= bertei_pkg::RST_BYTE;
            ptaps     <= bertei_pkg::RST_BYTE;
            pctrl     <= bertei_pkg::RST_BYTE;
            einj      <= bertei_pkg::RST_BYTE;
            st_enable <= '0;
        end else if (wr_take) begin
            unique case (idx)
                bertei_pkg::IDX_SEED3:  seed[3] <= wbyte;
                bertei_pkg::IDX_SEED2:  seed[2] <= wbyte;
                bertei_pkg::IDX_SEED1:  seed[1] <= wbyte;
                bertei_pkg::IDX_SEED0:  seed[0] <= wbyte;
                bertei_pkg::IDX_LENGTH: plength <= wbyte;
                bertei_pkg::IDX_TAPS:   ptaps   <= wbyte;
                bertei_pkg::IDX_PCTRL:  pctrl   <= wbyte;
                bertei_pkg::IDX_EINJ:   einj    <= wbyte & bertei_pkg::EINJ_MASK;
                bertei_pkg::IDX_IRQ_EN: st_enable <= wbyte[ST_W_L-1:0];
                default:                ;
            endcase
        end
    end

    // edges of the control bits ored with their pins
    assign latch_req  = pctrl[bertei_pkg::PC_LATCH] | latch_pin_s;
    assign load_req   = pctrl[bertei_pkg::PC_LOAD] | load_pin_s;
    assign latch_edge = latch_req & ~latch_req_d;
    assign load_edge  = load_req & ~load_req_d;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            latch_req_d <= 1'b0;
            load_req_d  <= 1'b0;
            single_d    <= 1'b0;
        end else begin
            latch_req_d <= latch_req;
            load_req_d  <= load_req;
            single_d    <= einj[bertei_pkg::EINJ_SINGLE];
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            single_pend <= 1'b0;
        end else if (einj[bertei_pkg::EINJ_SINGLE] && !single_d) begin
            single_pend <= 1'b1;
        end else if (tx_bit_en) begin
            single_pend <= 1'b0;
        end
    end

    // pattern generator: shift register of length+1 bits, top bit goes out
    always_comb begin
        if (pctrl[bertei_pkg::PC_ZSUP] && zrun == bertei_pkg::ZSUP_RUN) begin
            gen_bit = 1'b1;
        end else begin
            gen_bit = gen_sr[plength[4:0]];
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            gen_sr <= bertei_pkg::RST_SEED;
            zrun   <= 5'h00;
        end else if (load_edge) begin
            gen_sr <= {seed[3], seed[2], seed[1], seed[0]};
            zrun   <= 5'h00;
        end else if (tx_bit_en) begin
            // feedback from the length position, xored with the tap position when PC_TYPE is set
            if (pctrl[bertei_pkg::PC_TYPE]) begin
                gen_sr <= {gen_sr[30:0], gen_sr[plength[4:0]] ^ gen_sr[ptaps[4:0]]};
            end else begin
                gen_sr <= {gen_sr[30:0], gen_sr[plength[4:0]]};
            end
            zrun <= gen_bit ? 5'h00 : zrun + 5'h01;
        end
    end

    assign auto_hit = (rate_run(einj[2:0]) != 24'h000000)
                    && (err_cnt >= rate_run(einj[2:0]) - 24'h000001);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            err_cnt <= 24'h000000;
        end else if (load_edge || einj[2:0] == 3'h0) begin
            err_cnt <= 24'h000000;
        end else if (tx_bit_en) begin
            err_cnt <= auto_hit ? 24'h000000 : err_cnt + 24'h000001;
        end
    end

    assign err_now = auto_hit | single_pend;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tx_data <= 1'b0;
        end else if (tx_bit_en) begin
            tx_data <= gen_bit ^ err_now ^ einj[bertei_pkg::EINJ_TX_INV];
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rx_bit       <= 1'b0;
            rx_bit_valid <= 1'b0;
        end else begin
            rx_bit_valid <= rx_bit_en;
            if (rx_bit_en) begin
                rx_bit <= rx_data_s ^ einj[bertei_pkg::EINJ_RX_INV];
            end
        end
    end

    // count only when enabled and in sync
    assign cnt_step = rx_bit_en & ~inhibit_s & pattern_in_sync;
    assign cnt_wrap = cnt_step & (&bit_cnt);

    // latch and clear; a coincident bit is kept in the new count
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            bit_cnt      <= 32'h00000000;
            bits_latched <= 32'h00000000;
        end else if (latch_edge) begin
            bits_latched <= bit_cnt;
            bit_cnt      <= cnt_step ? 32'h00000001 : 32'h00000000;
        end else if (cnt_step) begin
            bit_cnt <= bit_cnt + 32'h00000001;
        end
    end

    // overflow and other events as sticky flags; set beats clear
    always_comb begin
        st_set = '0;
        st_set[bertei_pkg::ST_OVF]     = cnt_wrap & ~latch_edge;
        st_set[bertei_pkg::ST_LATCHED] = latch_edge;
        st_set[bertei_pkg::ST_ERR_INS] = tx_bit_en & err_now & ~load_edge;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_flags <= '0;
        end else if (wr_take && idx == bertei_pkg::IDX_IRQ_CLR) begin
            st_flags <= (st_flags & ~wbyte[ST_W_L-1:0]) | st_set;
        end else begin
            st_flags <= st_flags | st_set;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(st_flags & st_enable);
        end
    end

endmodule // bertei_top

// *** sim/bertei_chk.sv ***
// Purpose: port-level checks of the error insertion and bit count block
// Assumes: link clocks are slow pins, several core cycles per half period
// Notes:   bound to bertei_top below
`timescale 1ns/1ns
module bertei_chk (
    input wire logic        core_clk,    // block clock
    input wire logic        reset,       // async reset, active high
    input wire logic        psel,        // apb select
    input wire logic        penable,     // apb access phase
    input wire logic        pwrite,      // apb write
    input wire logic [7:0]  paddr,       // apb byte address
    input wire logic [31:0] prdata,      // apb read data
    input wire logic        pready,      // apb ready
    input wire logic        pslverr,     // apb error
    input wire logic        tx_clk,      // transmit link clock
    input wire logic        rx_clk,      // receive link clock
    input wire logic        tx_data,     // serial transmit data
    input wire logic        rx_bit,      // received bit
    input wire logic        rx_bit_valid // received bit strobe
);
    logic [5:0] idx;
    logic       mapped;
    logic [4:0] tx_s;
    assign idx = paddr[7:2];
    assign mapped = (idx <= bertei_pkg::IDX_BITS0) ||
                    (idx >= bertei_pkg::IDX_IRQ_STAT && idx <= bertei_pkg::IDX_IRQ_EN);
    // tx clock history; tx_data moves only just after an edge
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tx_s <= 5'h00;
        end else begin
            tx_s <= {tx_s[3:0], tx_clk};
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_err_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match address map");
    a_data_upper: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_clear_reads_zero: assert property (pready && !pwrite && idx == bertei_pkg::IDX_IRQ_CLR |-> prdata == 32'h0)
        else $error("clear register read not zero");
    a_rx_valid_edge: assert property ($rose(rx_clk) |-> ##[2:4] rx_bit_valid)
        else $error("no received bit after rx clock edge");
    a_rx_valid_pulse: assert property (rx_bit_valid |=> !rx_bit_valid)
        else $error("received bit strobe too long");
    a_rx_bit_stable: assert property ($changed(rx_bit) |-> rx_bit_valid)
        else $error("received bit moved without strobe");
    a_tx_stands: assert property ($changed(tx_data) |-> tx_s != 5'h00 && tx_s != 5'h1f)
        else $error("tx_data moved away from a tx clock edge");
endmodule // bertei_chk

bind bertei_top bertei_chk i_bertei_chk (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_clk(tx_clk),
    .rx_clk(rx_clk), .tx_data(tx_data), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid)
);

// *** sim/bertei_link.sv ***
// Purpose: line under test, loops transmitted data back to the receiver
// Assumes: one link clock serves both directions, 160 ns period
// Notes:   clock stands low while run is low; a begun pulse always completes
`timescale 1ns/1ns
module bertei_link (
    input  wire logic run,     // clock pulses while high
    input  wire logic tx_data, // from the block
    output logic      lclk,    // tx_clk and rx_clk
    output logic      rx_data  // looped back data
);
    initial begin
        lclk = 1'b0;
        rx_data = 1'b0;
    end
    always begin
        if (run === 1'b1) begin
            lclk = 1'b1;
            #80;
            lclk = 1'b0;
            #80;
        end else begin
            #10;
        end
    end
    // data moves on the falling edge, clear of sampling
    always @(negedge lclk) begin
        rx_data <= tx_data;
    end
endmodule // bertei_link

// *** sim/bertei_top_tb.sv ***
// Purpose: self-checking bench of the error insertion and bit count block
// Assumes: the link model loops tx_data back to rx_data
// Notes:   decade counts above 10^2 are too slow to run
`timescale 1ns/1ns
module bertei_top_tb;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        rx_count_inhibit = 1'b0;
    logic        count_latch_pin = 1'b0;
    logic        tx_load_pin = 1'b0;
    logic        pattern_in_sync = 1'b1;
    logic        run = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, lclk, rx_data, tx_data, rx_bit, rx_bit_valid, irq;
    int          errors = 0;
    int          compares = 0;
    always #5 core_clk = ~core_clk;
    bertei_top i_bertei_top (
        .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_clk(lclk), .rx_clk(lclk), .rx_data(rx_data), .rx_count_inhibit(rx_count_inhibit),
        .count_latch_pin(count_latch_pin), .tx_load_pin(tx_load_pin),
        .pattern_in_sync(pattern_in_sync), .tx_data(tx_data), .rx_bit(rx_bit),
        .rx_bit_valid(rx_bit_valid), .irq(irq)
    );
    bertei_link i_bertei_link (.run(run), .tx_data(tx_data), .lclk(lclk), .rx_data(rx_data));
    task automatic test_done();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, idx, wd, rd, e);
    endtask
    task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp, input logic eexp, input string what);
        logic [31:0] rd;
        logic        e;
        apb(1'b0, idx, 8'h00, rd, e);
        check(rd, {24'h000000, exp}, what);
        check({31'h0, e}, {31'h0, eexp}, what);
    endtask
    // ones on the wire and after rx inversion, one per bit
    task automatic sample(input int skip, input int n, output int txo, output int rxo);
        txo = 0;
        rxo = 0;
        repeat (skip) @(negedge lclk);
        repeat (n) begin
            @(negedge lclk);
            txo += (tx_data === 1'b1);
            rxo += (rx_bit === 1'b1);
        end
    endtask
    task automatic pulses(input int n);
        @(posedge core_clk) run <= 1'b1;
        repeat (n) @(posedge lclk);
        @(posedge core_clk) run <= 1'b0;
        repeat (20) @(posedge core_clk);
    endtask
    task automatic pin_pulse(input logic latch_sel);
        @(posedge core_clk);
        if (latch_sel) count_latch_pin <= 1'b1;
        else tx_load_pin <= 1'b1;
        repeat (4) @(posedge core_clk);
        count_latch_pin <= 1'b0;
        tx_load_pin <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask
    task automatic latch(input logic by_pin);
        if (by_pin) begin
            pin_pulse(1'b1);
        end else begin
            wr(bertei_pkg::IDX_PCTRL, 8'h10);
            wr(bertei_pkg::IDX_PCTRL, 8'h00);
            repeat (6) @(posedge core_clk);
        end
    endtask
    task automatic t_regs();
        rdchk(bertei_pkg::IDX_BITS3, 8'h00, 1'b0, "count byte reset");
        wr(bertei_pkg::IDX_EINJ, 8'h3f);
        rdchk(bertei_pkg::IDX_EINJ, 8'h3f, 1'b0, "control readback");
        for (int c = 0; c < 8; c++) begin
            wr(bertei_pkg::IDX_EINJ, 8'(c));
            rdchk(bertei_pkg::IDX_EINJ, 8'(c), 1'b0, "rate code readback");
        end
        wr(bertei_pkg::IDX_EINJ, 8'h00);
        wr(bertei_pkg::IDX_BITS0, 8'haa);
        rdchk(bertei_pkg::IDX_BITS0, 8'h00, 1'b0, "count byte read-only");
        rdchk(6'h0c, 8'h00, 1'b1, "unmapped index");
        $display("test regs done");
    endtask
    task automatic t_patterns();
        logic [7:0] pc [4] = '{8'h00, 8'h20, 8'h40, 8'h00};
        logic [7:0] ln [4] = '{8'h07, 8'h02, 8'h00, 8'h00};
        logic [7:0] s0 [4] = '{8'h01, 8'hff, 8'hfe, 8'hff};
        int         nb [4] = '{32, 28, 30, 8};
        int         ex [4] = '{4, 16, 2, 8};
        int         txo;
        int         rxo;
        for (int i = 0; i < 4; i++) begin
            wr(bertei_pkg::IDX_SEED0, s0[i]);
            wr(bertei_pkg::IDX_LENGTH, ln[i]);
            wr(bertei_pkg::IDX_TAPS, 8'h00);
            // the last load goes through the pin, the others through the bit
            if (i == 3) pin_pulse(1'b0);
            else wr(bertei_pkg::IDX_PCTRL, pc[i] | 8'h80);
            wr(bertei_pkg::IDX_PCTRL, pc[i]);
            sample(2, nb[i], txo, rxo);
            check(32'(txo), 32'(ex[i]), "ones per pattern period");
        end
        $display("test patterns done");
    endtask
    task automatic t_errors();
        logic [7:0] ei [6] = '{8'h00, 8'h01, 8'h02, 8'h20, 8'h30, 8'h10};
        int         nb [6] = '{40, 40, 200, 8, 8, 8};
        int         et [6] = '{40, 36, 198, 0, 0, 8};
        int         er [6] = '{40, 36, 198, 0, 8, 0};
        int         txo;
        int         rxo;
        for (int i = 0; i < 6; i++) begin
            wr(bertei_pkg::IDX_EINJ, ei[i]);
            sample(2, nb[i], txo, rxo);
            check(32'(txo), 32'(et[i]), "transmitted ones");
            check(32'(rxo), 32'(er[i]), "received ones");
        end
        wr(bertei_pkg::IDX_EINJ, 8'h00);
        $display("test errors done");
    endtask
    task automatic t_single();
        int         ex [3] = '{15, 16, 15};
        int         txo;
        int         rxo;
        for (int i = 0; i < 3; i++) begin
            if (i == 2) wr(bertei_pkg::IDX_EINJ, 8'h00);
            wr(bertei_pkg::IDX_EINJ, 8'h08);
            sample(0, 16, txo, rxo);
            check(32'(txo), 32'(ex[i]), "single error count");
        end
        wr(bertei_pkg::IDX_EINJ, 8'h00);
        $display("test single done");
    endtask
    task automatic t_count();
        latch(1'b0);
        pulses(5);
        latch(1'b1);
        for (int b = 0; b < 4; b++) begin
            rdchk(6'(bertei_pkg::IDX_BITS3 + b), (b == 3) ? 8'h05 : 8'h00, 1'b0, "count byte");
        end
        @(posedge core_clk) rx_count_inhibit <= 1'b1;
        pulses(3);
        @(posedge core_clk) rx_count_inhibit <= 1'b0;
        pattern_in_sync <= 1'b0;
        pulses(3);
        @(posedge core_clk) pattern_in_sync <= 1'b1;
        pulses(2);
        latch(1'b0);
        rdchk(bertei_pkg::IDX_BITS0, 8'h02, 1'b0, "count while held");
        $display("test count done");
    endtask
    task automatic t_irq();
        wr(bertei_pkg::IDX_IRQ_CLR, 8'h07);
        wr(bertei_pkg::IDX_IRQ_EN, 8'h02);
        latch(1'b0);
        check({31'h0, irq}, 32'h1, "irq raised by latch");
        wr(bertei_pkg::IDX_IRQ_CLR, 8'h02);
        repeat (3) @(posedge core_clk);
        check({31'h0, irq}, 32'h0, "irq cleared");
        wr(bertei_pkg::IDX_IRQ_EN, 8'h00);
        latch(1'b1);
        check({31'h0, irq}, 32'h0, "irq masked");
        rdchk(bertei_pkg::IDX_IRQ_STAT, 8'h02, 1'b0, "latched status");
        rdchk(bertei_pkg::IDX_IRQ_CLR, 8'h00, 1'b0, "clear reads zero");
        $display("test irq done");
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        t_regs();
        wr(bertei_pkg::IDX_SEED3, 8'hff);
        wr(bertei_pkg::IDX_SEED2, 8'hff);
        wr(bertei_pkg::IDX_SEED1, 8'hff);
        @(posedge core_clk) run <= 1'b1;
        t_patterns();
        t_errors();
        t_single();
        @(posedge core_clk) run <= 1'b0;
        repeat (20) @(posedge core_clk);
        t_count();
        t_irq();
        test_done();
    end
    // the run needs about 100 us
    initial begin
        #400000;
        errors++;
        test_done();
    end
endmodule // bertei_top_tb
